/* src/spi_data_status_irq_regs.sv */
// serial peripheral port: data, status, interrupt mask and block-transfer logic
// assumes link pins arrive asynchronously; memory port answers a read in the same cycle MEM_RD is high
//
// What this block does
// [R1] received word right-justified, bits above word length read zero
// [R2] master: end-of-transfer select lines captured into receive word; slave: zero
// [R3] software writes transmit word right-justified, LSB in bit zero
// [R4] per-word select code used only in variable-select master mode
// [R5] software never writes all-ones select code while decoding is off
// [R6] decoding off: lowest zero bit of code drives its one select low
// [R7] decoding on: select lines driven directly by the code
// [R8] receive-ready set when a finished word is stored in the receive word, cleared by receive data read
// [R9] transmit-empty cleared by transmit write, set when word enters serializer
// [R10] transmit-empty zero at reset and when disabled; enable sets it
// [R11] mode fault flag sticks until status register read
// [R12] mode fault when master and slave-select input pulled low
// [R13] overrun on second receive load without read; status read clears
// [R14] receive-end status bit shows live receive channel end
// [R15] transmit-end status bit shows live transmit channel end
// [R16] enabled status in bit 16
// [R17] enable-set write ones set mask bits
// [R18] enable-clear write ones clear mask bits
// [R19] mask readable at status bit positions
// [R20] interrupt output high when any flag set with mask bit
// [R21] block transfer bumps pointer, drops counter, stops at zero with end status
// [R22] software loads receive pointer before starting receive block transfer
`timescale 1ns/1ps
`default_nettype none

module spi_data_status_irq_regs
  import spi_regs_pkg::*;
(
  // clock and reset
  input  wire logic              CLOCK,
  input  wire logic              NRST,
  // register port
  input  wire logic [AW-1:0]     ADDR,
  input  wire logic [31:0]       WDATA,
  input  wire logic              WR_EN,
  input  wire logic              RD_EN,
  output logic      [31:0]       RDATA,
  output logic                   IRQ,
  // block-transfer memory port
  output logic                   MEM_WR,
  output logic                   MEM_RD,
  output logic      [31:0]       MEM_ADDR,
  output logic      [31:0]       MEM_WDATA,
  input  wire logic [31:0]       MEM_RDATA,
  // serial link
  input  wire logic              SPCK_IN,
  output logic                   SPCK_OUT,
  output logic                   SPCK_OE_N,
  input  wire logic              MOSI_IN,
  output logic                   MOSI_OUT,
  output logic                   MOSI_OE_N,
  input  wire logic              MISO_IN,
  output logic                   MISO_OUT,
  output logic                   MISO_OE_N,
  output logic      [3:0]        CHIP_SELECT_OUT_N,
  output logic                   CHIP_SELECT_OE_N,
  input  wire logic              SLAVE_SELECT_IN_N
);

  typedef enum logic {IDLE, XFER} xfer_t;

  typedef struct packed {
    logic              enabled;
    logic              master;
    logic              variable_select_mode;
    logic              select_decode_enable;
    logic [3:0]        mode_code;
    logic              cpol;
    logic [3:0]        bits;
    logic [7:0]        div_cfg;
    logic [N_SRC-1:0]  mask;
    logic              rx_ready_flag;
    logic              tx_empty_flag;
    logic              mode_fault_flag;
    logic              overrun_flag;
    logic [15:0]       rx_word;
    logic [3:0]        rx_sel;
    logic [15:0]       tx_word;
    logic [3:0]        tx_code;
    logic [31:0]       rx_buffer_pointer;
    logic [15:0]       rx_cnt;
    logic [31:0]       tx_ptr;
    logic [15:0]       tx_cnt;
    logic              fetch_pend;
    xfer_t             xfer;
    logic [15:0]       shifter;
    logic [4:0]        bitcnt;
    logic [7:0]        div;
    logic              samp;
    logic              sck;
    logic [3:0]        sel;
    logic [2:0]        spck_s;
    logic [2:0]        nss_s;
    logic [2:0]        mosi_s;
    logic [2:0]        miso_s;
    logic              spck_f;
    logic              nss_f;
    logic              mosi_f;
    logic              miso_f;
    logic [31:0]       rdata;
    logic              mem_wr;
    logic              mem_rd;
    logic [31:0]       mem_addr;
    logic [31:0]       mem_wdata;
  } state_t;

  state_t st;
  state_t next_st;

  // a change counts only once the second and third stages agree
  function automatic logic filt(input logic [2:0] s, input logic f);
    filt = (s[2] == s[1]) ? s[2] : f;
  endfunction

  // active-high one-of-four or pass-through select
  function automatic logic [3:0] decode(input logic [3:0] code, input logic dec);
    logic [3:0] low;
    low = 4'h0;
    if (dec)
      low = ~code;                                       // [R7]
    else if (!code[0])
      low = 4'h1;                                        // [R6]
    else if (!code[1])
      low = 4'h2;                                        // [R6]
    else if (!code[2])
      low = 4'h4;                                        // [R6]
    else if (!code[3])
      low = 4'h8;                                        // [R6]
    // all ones selects nothing, software must not use it [R5]
    decode = low;
  endfunction

  logic [N_SRC-1:0] status;

  always_comb
  begin
    status = {st.tx_cnt == 16'h0000,                     // [R15]
              st.rx_cnt == 16'h0000,                     // [R14]
              st.overrun_flag, st.mode_fault_flag, st.tx_empty_flag, st.rx_ready_flag};
  end

  always_comb
  begin
    logic [4:0]  len;
    logic [15:0] lenmask;
    logic        edge_seen;
    logic        lead;
    logic        trail;
    logic        done;
    logic        fault;
    logic [15:0] shifted;
    logic [3:0]  code;
    len       = 5'(st.bits) + MIN_BITS;
    lenmask   = 16'hffff;
    edge_seen = 1'b0;
    lead      = 1'b0;
    trail     = 1'b0;
    done      = 1'b0;
    fault     = 1'b0;
    shifted   = {st.shifter[14:0], st.samp};
    code      = st.variable_select_mode ? st.tx_code : st.mode_code;   // [R4]
    next_st   = st;
    next_st.mem_wr = 1'b0;
    next_st.mem_rd = 1'b0;
    if (len > MAX_BITS)
      len = MAX_BITS;
    lenmask = 16'hffff >> (5'd16 - len);

    // input synchronisers
    next_st.spck_s = {st.spck_s[1:0], SPCK_IN};
    next_st.nss_s  = {st.nss_s[1:0], SLAVE_SELECT_IN_N};
    next_st.mosi_s = {st.mosi_s[1:0], MOSI_IN};
    next_st.miso_s = {st.miso_s[1:0], MISO_IN};
    next_st.spck_f = filt(st.spck_s, st.spck_f);
    next_st.nss_f  = filt(st.nss_s, st.nss_f);
    next_st.mosi_f = filt(st.mosi_s, st.mosi_f);
    next_st.miso_f = filt(st.miso_s, st.miso_f);
    edge_seen = next_st.spck_f != st.spck_f;
    lead  = edge_seen && (next_st.spck_f != st.cpol);
    trail = edge_seen && (next_st.spck_f == st.cpol);

    // serializer: data captured on the leading edge, changed on the trailing one
    if (!st.enabled)
    begin
      next_st.xfer = IDLE;
      next_st.sel  = 4'h0;
      next_st.sck  = st.cpol;
      next_st.tx_empty_flag = 1'b0;                      // [R10]
    end
    else if (st.master)
    begin
      fault = !st.nss_f;                                 // [R12]
      unique case (st.xfer)
        IDLE:
        begin
          next_st.sck = st.cpol;
          // a divider below two stops the link
          if (!st.tx_empty_flag && st.div_cfg >= DIV_MIN)
          begin
            next_st.shifter = st.tx_word << (5'd16 - len);
            next_st.tx_empty_flag = 1'b1;                // [R9]
            next_st.sel    = decode(code, st.select_decode_enable);
            next_st.xfer   = XFER;
            next_st.div    = 8'h00;
            next_st.bitcnt = 5'h00;
          end
        end
        XFER:
        begin
          if (st.div == st.div_cfg - 8'h01)
          begin
            next_st.div = 8'h00;
            next_st.sck = ~st.sck;
            if (st.sck == st.cpol)
              next_st.samp = st.miso_f;
            else
            begin
              next_st.shifter = shifted;
              next_st.bitcnt  = st.bitcnt + 5'h01;
              if (st.bitcnt + 5'h01 == len)
              begin
                done = 1'b1;
                next_st.xfer = IDLE;
                next_st.sel  = 4'h0;
              end
            end
          end
          else
            next_st.div = st.div + 8'h01;
        end
      endcase
    end
    else
    begin
      unique case (st.xfer)
        IDLE:
        begin
          if (!st.nss_f)
          begin
            // an empty holding register resends the last word
            next_st.shifter = st.tx_word << (5'd16 - len);
            next_st.tx_empty_flag = 1'b1;                // [R9]
            next_st.bitcnt = 5'h00;
            next_st.xfer   = XFER;
          end
        end
        XFER:
        begin
          if (st.nss_f)
            next_st.xfer = IDLE;
          else if (lead)
            next_st.samp = st.mosi_f;
          else if (trail)
          begin
            next_st.shifter = shifted;
            next_st.bitcnt  = st.bitcnt + 5'h01;
            if (st.bitcnt + 5'h01 == len)
            begin
              done = 1'b1;
              next_st.bitcnt = 5'h00;
              next_st.shifter = st.tx_word << (5'd16 - len);
              next_st.tx_empty_flag = 1'b1;              // [R9]
            end
          end
        end
      endcase
    end

    // register reads, with their clearing side effects
    next_st.rdata = RESET_WORD;
    if (RD_EN)
    begin
      case (ADDR)
        OFS_MODE:
          next_st.rdata = {12'h000, st.mode_code, 13'h0000, st.select_decode_enable,
                           st.variable_select_mode, st.master};
        OFS_RX_DATA:
        begin
          next_st.rdata = {12'h000, st.rx_sel, st.rx_word};
          next_st.rx_ready_flag = 1'b0;                  // [R8]
        end
        OFS_STATUS:
        begin
          next_st.rdata = {15'h0000, st.enabled, 10'h000, status};   // [R16]
          next_st.mode_fault_flag = 1'b0;                // [R11]
          next_st.overrun_flag    = 1'b0;                // [R13]
        end
        OFS_IRQ_VIEW: next_st.rdata = {26'h0000000, st.mask};        // [R19]
        OFS_RX_PTR:   next_st.rdata = st.rx_buffer_pointer;
        OFS_RX_CNT:   next_st.rdata = {16'h0000, st.rx_cnt};
        OFS_TX_PTR:   next_st.rdata = st.tx_ptr;
        OFS_TX_CNT:   next_st.rdata = {16'h0000, st.tx_cnt};
        OFS_LINK_CFG:
          next_st.rdata = {16'h0000, st.div_cfg, st.bits, 3'h0, st.cpol};
        default:      next_st.rdata = RESET_WORD;
      endcase
    end

    // block transfers: receive takes the memory port first, none while counter is zero
    if (st.rx_ready_flag && st.rx_cnt != 16'h0000 && !st.fetch_pend)
    begin
      next_st.mem_wr    = 1'b1;
      next_st.mem_addr  = st.rx_buffer_pointer;          // [R22]
      next_st.mem_wdata = {12'h000, st.rx_sel, st.rx_word};
      next_st.rx_buffer_pointer = st.rx_buffer_pointer + PTR_STEP;   // [R21]
      next_st.rx_cnt    = st.rx_cnt - 16'h0001;          // [R21]
      next_st.rx_ready_flag = 1'b0;                      // [R8]
    end
    else if (st.enabled && st.tx_empty_flag && st.tx_cnt != 16'h0000 && !st.fetch_pend)
    begin
      next_st.mem_rd     = 1'b1;
      next_st.mem_addr   = st.tx_ptr;
      next_st.fetch_pend = 1'b1;
    end
    if (st.fetch_pend)
    begin
      next_st.fetch_pend    = 1'b0;
      next_st.tx_word       = MEM_RDATA[15:0];
      next_st.tx_code       = MEM_RDATA[SEL_LSB+3:SEL_LSB];
      next_st.tx_empty_flag = 1'b0;                      // [R9]
      next_st.tx_ptr        = st.tx_ptr + PTR_STEP;      // [R21]
      next_st.tx_cnt        = st.tx_cnt - 16'h0001;      // [R21]
    end

    // register writes
    if (WR_EN)
    begin
      case (ADDR)
        OFS_CTRL:
        begin
          if (WDATA[CTRL_DISABLE])
          begin
            // disable wins over a simultaneous enable
            next_st.enabled = 1'b0;
            next_st.tx_empty_flag = 1'b0;                // [R10]
          end
          else if (WDATA[CTRL_ENABLE] && !st.enabled)
          begin
            next_st.enabled = 1'b1;
            next_st.tx_empty_flag = 1'b1;                // [R10]
          end
        end
        OFS_MODE:
        begin
          next_st.master               = WDATA[MODE_MASTER];
          next_st.variable_select_mode = WDATA[MODE_VARSEL];
          next_st.select_decode_enable = WDATA[MODE_DECODE];
          next_st.mode_code            = WDATA[MODE_SEL_LSB+3:MODE_SEL_LSB];
        end
        OFS_TX_DATA:
        begin
          next_st.tx_word = WDATA[15:0];                 // [R3]
          next_st.tx_code = WDATA[SEL_LSB+3:SEL_LSB];
          next_st.tx_empty_flag = 1'b0;                  // [R9]
        end
        OFS_IRQ_SET:  next_st.mask = st.mask | WDATA[N_SRC-1:0];     // [R17]
        OFS_IRQ_CLR:  next_st.mask = st.mask & ~WDATA[N_SRC-1:0];    // [R18]
        OFS_RX_PTR:   next_st.rx_buffer_pointer = WDATA;
        OFS_RX_CNT:   next_st.rx_cnt = WDATA[15:0];
        OFS_TX_PTR:   next_st.tx_ptr = WDATA;
        OFS_TX_CNT:   next_st.tx_cnt = WDATA[15:0];
        OFS_LINK_CFG:
        begin
          next_st.cpol    = WDATA[CFG_CPOL];
          next_st.bits    = WDATA[CFG_BITS_LSB+3:CFG_BITS_LSB];
          next_st.div_cfg = WDATA[CFG_DIV_LSB+7:CFG_DIV_LSB];
        end
        default:
        begin
        end
      endcase
    end

    // hardware events last, so a set wins over a clear in the same cycle
    if (fault)
      next_st.mode_fault_flag = 1'b1;                    // [R11]
    if (done)
    begin
      next_st.rx_word = shifted & lenmask;               // [R1]
      next_st.rx_sel  = st.master ? ~st.sel : 4'h0;      // [R2]
      next_st.rx_ready_flag = 1'b1;                      // [R8]
      if (st.rx_ready_flag)
        next_st.overrun_flag = 1'b1;                     // [R13]
    end

    // software reset clears everything, including a pending fetch
    if (WR_EN && ADDR == OFS_CTRL && WDATA[CTRL_SWRESET])
      next_st = '0;
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      st <= '0;
    else
      st <= next_st;
  end

  assign RDATA             = st.rdata;
  assign IRQ               = |(status & st.mask);        // [R20]
  assign MEM_WR            = st.mem_wr;
  assign MEM_RD            = st.mem_rd;
  assign MEM_ADDR          = st.mem_addr;
  assign MEM_WDATA         = st.mem_wdata;
  assign SPCK_OUT          = st.sck;
  assign SPCK_OE_N         = !(st.enabled && st.master);
  assign MOSI_OUT          = st.shifter[15];
  assign MOSI_OE_N         = !(st.enabled && st.master);
  assign MISO_OUT          = st.shifter[15];
  assign MISO_OE_N         = !(st.enabled && !st.master && !st.nss_f);
  assign CHIP_SELECT_OUT_N = ~st.sel;                    // [R6]
  assign CHIP_SELECT_OE_N  = !(st.enabled && st.master);

endmodule

`default_nettype wire

/* src/spi_regs_pkg.sv */
// register map, field positions and reset values of the serial port block
// assumes a 32-bit register port addressed in bytes, one word per register
package spi_regs_pkg;

  localparam int unsigned AW = 8;

  // byte offsets
  localparam logic [AW-1:0] OFS_CTRL      = 8'h00;
  localparam logic [AW-1:0] OFS_MODE      = 8'h04;
  localparam logic [AW-1:0] OFS_RX_DATA   = 8'h08;
  localparam logic [AW-1:0] OFS_TX_DATA   = 8'h0c;
  localparam logic [AW-1:0] OFS_STATUS    = 8'h10;
  localparam logic [AW-1:0] OFS_IRQ_SET   = 8'h14;
  localparam logic [AW-1:0] OFS_IRQ_CLR   = 8'h18;
  localparam logic [AW-1:0] OFS_IRQ_VIEW  = 8'h1c;
  localparam logic [AW-1:0] OFS_RX_PTR    = 8'h20;
  localparam logic [AW-1:0] OFS_RX_CNT    = 8'h24;
  localparam logic [AW-1:0] OFS_TX_PTR    = 8'h28;
  localparam logic [AW-1:0] OFS_TX_CNT    = 8'h2c;
  localparam logic [AW-1:0] OFS_LINK_CFG  = 8'h30;

  // control word
  localparam int unsigned CTRL_ENABLE   = 0;
  localparam int unsigned CTRL_DISABLE  = 1;
  localparam int unsigned CTRL_SWRESET  = 7;

  // mode word
  localparam int unsigned MODE_MASTER   = 0;
  localparam int unsigned MODE_VARSEL   = 1;
  localparam int unsigned MODE_DECODE   = 2;
  localparam int unsigned MODE_SEL_LSB  = 16;

  // link configuration word
  localparam int unsigned CFG_CPOL      = 0;
  localparam int unsigned CFG_BITS_LSB  = 4;
  localparam int unsigned CFG_DIV_LSB   = 8;

  // data words: 16-bit data field, select code above it
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned SEL_LSB       = 16;
  localparam logic [4:0]  MIN_BITS      = 5'h08;
  localparam logic [4:0]  MAX_BITS      = 5'h10;
  localparam logic [7:0]  DIV_MIN       = 8'h02;

  // status and mask bit positions
  localparam int unsigned ST_RX_READY   = 0;
  localparam int unsigned ST_TX_EMPTY   = 1;
  localparam int unsigned ST_MODE_FAULT = 2;
  localparam int unsigned ST_OVERRUN    = 3;
  localparam int unsigned ST_RX_END     = 4;
  localparam int unsigned ST_TX_END     = 5;
  localparam int unsigned ST_ENABLED    = 16;
  localparam int unsigned N_SRC         = 6;

  // block-transfer pointer step in bytes per word
  localparam logic [31:0] PTR_STEP      = 32'h0000_0002;

  localparam logic [31:0] RESET_WORD    = 32'h0000_0000;

endpackage

/* tb/spi_data_status_irq_regs_assertions.sv */
// port-level checker for the serial port register block, bound to its top module
// assumes one clock domain and the register map of the package
`timescale 1ns/1ps
`default_nettype none

module spi_data_status_irq_regs_checker
  import spi_regs_pkg::*;
(
  // clock and reset
  input wire logic          CLOCK,
  input wire logic          NRST,
  // register port
  input wire logic [AW-1:0] ADDR,
  input wire logic [31:0]   WDATA,
  input wire logic          WR_EN,
  input wire logic          RD_EN,
  input wire logic [31:0]   RDATA,
  input wire logic          IRQ,
  // link
  input wire logic [3:0]    CHIP_SELECT_OUT_N,
  input wire logic          CHIP_SELECT_OE_N,
  input wire logic          SLAVE_SELECT_IN_N
);
  logic [5:0] mask;
  logic       en;
  logic       master;
  logic       decode;
  logic [3:0] low_cnt;
  wire logic  wr_ctrl = WR_EN && ADDR == OFS_CTRL;
  wire logic  rd_st   = RD_EN && ADDR == OFS_STATUS;

  // shadow rebuilt from register writes and the slave-select pin, never from the design's state
  always_ff @(posedge CLOCK or negedge NRST)
    if (!NRST)
      {mask, en, master, decode, low_cnt} <= '0;
    else if (wr_ctrl && WDATA[CTRL_SWRESET])
      {mask, en, master, decode, low_cnt} <= '0;
    else
    begin
      if (WR_EN && ADDR == OFS_IRQ_SET)
        mask <= mask | WDATA[5:0];
      if (WR_EN && ADDR == OFS_IRQ_CLR)
        mask <= mask & ~WDATA[5:0];
      if (wr_ctrl && (WDATA[CTRL_ENABLE] || WDATA[CTRL_DISABLE]))
        en <= !WDATA[CTRL_DISABLE];
      if (WR_EN && ADDR == OFS_MODE)
        {master, decode} <= {WDATA[MODE_MASTER], WDATA[MODE_DECODE]};
      // saturates so a long fault never wraps back below the threshold
      low_cnt <= (master && en && !SLAVE_SELECT_IN_N) ? low_cnt + {3'h0, low_cnt != 4'hf} : 4'h0;
    end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  chk_rx_upper_zero: assert property (RD_EN && ADDR == OFS_RX_DATA |=> RDATA[31:20] == 12'h000)
    else $error("receive word bits above the select field not zero");
  chk_enabled_bit: assert property (rd_st |=> RDATA[ST_ENABLED] == $past(en))
    else $error("enabled status bit disagrees with enable history");
  chk_txe_disabled: assert property (rd_st && !en |=> !RDATA[ST_TX_EMPTY])
    else $error("transmit empty set while disabled");
  chk_status_unused: assert property (rd_st |=> RDATA[31:17] == 15'h0000 && RDATA[15:6] == 10'h000)
    else $error("unused status bits not zero");
  chk_mask_view: assert property (RD_EN && ADDR == OFS_IRQ_VIEW |=> RDATA == {26'h0, $past(mask)})
    else $error("mask view differs from set and clear history");
  chk_irq_quiet: assert property (mask == 6'h00 |-> !IRQ)
    else $error("interrupt raised with every source masked");
  chk_select_onehot: assert property (!CHIP_SELECT_OE_N && master && !decode
    |-> CHIP_SELECT_OUT_N inside {4'he, 4'hd, 4'hb, 4'h7, 4'hf})
    else $error("more than one select driven low without decoding");
  chk_fault_seen: assert property (low_cnt >= 4'h8 && rd_st |=> RDATA[ST_MODE_FAULT])
    else $error("mode fault not reported while slave select held low");
endmodule

bind spi_data_status_irq_regs spi_data_status_irq_regs_checker chk_i (
  .CLOCK(CLOCK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR_EN(WR_EN), .RD_EN(RD_EN),
  .RDATA(RDATA), .IRQ(IRQ), .CHIP_SELECT_OUT_N(CHIP_SELECT_OUT_N),
  .CHIP_SELECT_OE_N(CHIP_SELECT_OE_N), .SLAVE_SELECT_IN_N(SLAVE_SELECT_IN_N));
`default_nettype wire

/* tb/spi_data_status_irq_regs_test.sv */
// self-checking bench for the serial port register block with one peripheral on the link
// assumes 40 MHz clock, 8-bit words at a half-period divider of 5
`timescale 1ns/1ps
`default_nettype none

module spi_data_status_irq_regs_test
  import spi_regs_pkg::*;
;
  typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;} row_t;
  logic          clock, nrst, wr_en, rd_en, ss_n, irq, spck, mosi, miso;
  logic [AW-1:0] addr;
  logic [31:0]   wdata, rdata, v;
  logic [3:0]    cs_n, seen_cs;
  logic [7:0]    prx;
  int            mismatches, check_count;
  row_t rows[12] = '{
    '{OFS_IRQ_SET, 32'h0000003f, OFS_IRQ_VIEW, 32'h3f}, '{OFS_IRQ_CLR, 32'h00000005, OFS_IRQ_VIEW, 32'h3a},
    '{OFS_IRQ_SET, 32'h00000000, OFS_IRQ_VIEW, 32'h3a}, '{OFS_IRQ_CLR, 32'hffffffc0, OFS_IRQ_VIEW, 32'h3a},
    '{OFS_IRQ_SET, 32'hffffffc1, OFS_IRQ_VIEW, 32'h3b}, '{OFS_IRQ_CLR, 32'h0000003f, OFS_IRQ_VIEW, 32'h00},
    '{8'h40, 32'hffffffff, 8'h40, 32'h0}, '{OFS_RX_PTR, 32'h12345678, OFS_RX_PTR, 32'h12345678},
    '{OFS_RX_CNT, 32'h00000003, OFS_STATUS, 32'h20}, '{OFS_RX_CNT, 32'h00000000, OFS_STATUS, 32'h30},
    '{OFS_TX_CNT, 32'h00000001, OFS_STATUS, 32'h10}, '{OFS_TX_CNT, 32'h00000000, OFS_STATUS, 32'h30}};
  // don't-care bits set on purpose; all-ones never sent while decoding is off
  logic [3:0] codes[4] = '{4'b0100, 4'b1001, 4'b0011, 4'b0111};
  logic [3:0] outs[4]  = '{4'b1110, 4'b1101, 4'b1011, 4'b0111};

  spi_data_status_irq_regs DUT (.CLOCK(clock), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR_EN(wr_en),
    .RD_EN(rd_en), .RDATA(rdata), .IRQ(irq), .MEM_WR(), .MEM_RD(), .MEM_ADDR(), .MEM_WDATA(),
    .MEM_RDATA(32'h0), .SPCK_IN(1'b0), .SPCK_OUT(spck), .SPCK_OE_N(), .MOSI_IN(1'b0), .MOSI_OUT(mosi),
    .MOSI_OE_N(), .MISO_IN(miso), .MISO_OUT(), .MISO_OE_N(), .CHIP_SELECT_OUT_N(cs_n),
    .CHIP_SELECT_OE_N(), .SLAVE_SELECT_IN_N(ss_n));
  spi_peripheral_model peer (.sck(spck), .cs_n(cs_n), .mosi(mosi), .miso(miso), .seen_cs(seen_cs), .rx(prx));

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] ex);
    check_count++;
    if (got !== ex)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, ex, got);
    end
  endtask

  // each bus task is entered just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    // strobe of a previous write still up: let an edge pass before raising it again
    if (wr_en)
      @(posedge clock);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rdata;
    @(posedge clock);
  endtask

  task automatic xfer(input logic [3:0] code, input logic [7:0] d);
    int n;
    wr(OFS_TX_DATA, {12'h0, code, 8'h00, d});
    rd(OFS_STATUS, v);
    chk("tx empty after write", {31'h0, v[ST_TX_EMPTY]}, 32'h0);
    // wait for the selects to be released: an unread earlier word keeps rx ready high
    n = 0;
    while (cs_n !== 4'hf && n < 300)
    begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    rd(OFS_STATUS, v);
    chk("word done in time", {31'h0, n < 300}, 32'h1);
    chk("rx ready after word", {31'h0, v[ST_RX_READY]}, 32'h1);
    chk("tx empty after load", {31'h0, v[ST_TX_EMPTY]}, 32'h1);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    results;
  end

  initial
  begin
    {nrst, wr_en, rd_en, addr, wdata} = '0;
    ss_n = 1'b1;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd(OFS_STATUS, v);
    chk("status at reset", v & 32'h0001003f, 32'h30);
    rd(OFS_RX_DATA, v);
    chk("rx data at reset", v, 32'h0);
    foreach (rows[i])
    begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra, v);
      chk("register row", v, rows[i].ex);
    end
    wr(OFS_LINK_CFG, 32'h00000500);
    wr(OFS_MODE, 32'h00000003);
    wr(OFS_CTRL, 32'h00000001);
    rd(OFS_STATUS, v);
    chk("enabled state", v & 32'h00010002, 32'h00010002);
    wr(OFS_IRQ_SET, 32'h00000002);
    #1 chk("irq unmasked", {31'h0, irq}, 32'h1);
    @(posedge clock);
    wr(OFS_IRQ_CLR, 32'h00000002);
    #1 chk("irq masked", {31'h0, irq}, 32'h0);
    @(posedge clock);
    for (int i = 0; i < 4; i++)
    begin
      xfer(codes[i], 8'h5a ^ 8'(i));
      chk("select seen", {28'h0, seen_cs}, {28'h0, outs[i]});
      chk("peer got word", {24'h0, prx}, {24'h0, 8'h5a ^ 8'(i)});
      rd(OFS_RX_DATA, v);
      chk("rx word", v, {12'h0, outs[i], 8'h00, 8'hc3});
      rd(OFS_STATUS, v);
      chk("rx ready cleared", {31'h0, v[ST_RX_READY]}, 32'h0);
    end
    // fixed select: the per-word code must be ignored
    wr(OFS_MODE, 32'h00010001);
    xfer(4'b0100, 8'h11);
    chk("fixed select", {28'h0, seen_cs}, 32'hd);
    rd(OFS_RX_DATA, v);
    wr(OFS_MODE, 32'h00000007);
    xfer(4'b1010, 8'h22);
    chk("decoded select", {28'h0, seen_cs}, 32'ha);
    // second word lands unread
    xfer(4'b1010, 8'h33);
    chk("overrun set", {31'h0, v[ST_OVERRUN]}, 32'h1);
    rd(OFS_STATUS, v);
    chk("overrun cleared", v & 32'h00000009, 32'h1);
    rd(OFS_RX_DATA, v);
    chk("decoded rx word", v, {12'h0, 4'ha, 8'h00, 8'hc3});
    ss_n <= 1'b0;
    repeat (12) @(posedge clock);
    rd(OFS_STATUS, v);
    chk("mode fault live", {31'h0, v[ST_MODE_FAULT]}, 32'h1);
    ss_n <= 1'b1;
    repeat (5) @(posedge clock);
    rd(OFS_STATUS, v);
    chk("mode fault", {31'h0, v[ST_MODE_FAULT]}, 32'h1);
    rd(OFS_STATUS, v);
    chk("mode fault cleared", {31'h0, v[ST_MODE_FAULT]}, 32'h0);
    wr(OFS_CTRL, 32'h00000003);
    rd(OFS_STATUS, v);
    chk("disabled state", v & 32'h00010002, 32'h0);
    results;
  end
endmodule
`default_nettype wire

/* tb/spi_peripheral_model.sv */
// serial peripheral on the far side of the link: answers a fixed 8-bit word, records selects
// assumes clock idles low, data changed on falling and captured on rising clock edges
`timescale 1ns/1ps
`default_nettype none

module spi_peripheral_model #(
  parameter logic [7:0] REPLY = 8'hc3
) (
  // link
  input  wire logic       sck,
  input  wire logic [3:0] cs_n,
  input  wire logic       mosi,
  output logic            miso,
  // observation
  output logic [3:0]      seen_cs,
  output logic [7:0]      rx
);
  logic [7:0] sh;
  logic       active;
  wire logic  sel = cs_n != 4'hf;

  initial
  begin
    miso = 1'b0;
    active = 1'b0;
    rx = 8'h00;
  end

  // released line toggles so a stale bit is never taken as data
  always @(posedge sel or negedge sel or negedge sck)
    if (!sel)
    begin
      active = 1'b0;
      miso = ~miso;
    end
    else if (!active)
    begin
      active = 1'b1;
      seen_cs = cs_n;
      sh = REPLY;
      miso = REPLY[7];
    end
    else
    begin
      sh = sh << 1;
      miso = sh[7];
    end

  always @(posedge sck)
    if (sel)
      rx = {rx[6:0], mosi};
endmodule
`default_nettype wire
